// ### rtl/sps_pop_seq.sv
// Purpose: sequences the pop, pop-return-zero and pop-return ops
// Assumes: all inputs come from core logic on ref_clk
// Notes: one load outstanding at a time; data bus 64 bits
`timescale 1ns/10ps
`include "sps_defs.svh"
module sps_pop_seq #(
  parameter logic NONIDEM_OK = 1'b0 // loads to such regions allowed
) (
  input wire logic ref_clk, // core clock
  input wire logic rst, // async reset, active high
  input wire sps_pkg::sps_base_type base_mode, // integer base
  input wire logic start, // issue pulse, taken while idle
  input wire sps_pkg::sps_op_type op, // which pop flavour
  input wire logic [3:0] rlist, // register-list code
  input wire logic [1:0] spimm, // extra-frame field
  input wire logic [63:0] sp_val, // stack pointer at issue
  input wire logic trap_req, // pending trap or interrupt
  input wire logic commit_ok, // instruction sure to commit
  input wire logic ld_gnt, // load request accepted
  input wire logic ld_nonidem, // ld_addr is non-idempotent
  input wire logic ld_rvalid, // load response pulse
  input wire logic [63:0] ld_rdata, // load response data
  input wire logic ld_err, // load response is a fault
  output logic busy, // sequence in progress
  output logic ld_req, // load request, held until grant
  output logic [63:0] ld_addr, // load byte address
  output logic ld_dword, // 1 doubleword, 0 word
  output logic rf_we, // register write pulse
  output logic [4:0] rf_waddr, // register index
  output logic [63:0] rf_wdata, // register data
  output logic sp_we, // stack pointer write pulse
  output logic [63:0] sp_wdata, // new stack pointer
  output logic pc_we, // return jump pulse
  output logic [63:0] pc_wdata, // return target
  output logic exc_valid, // exception pulse
  output logic [3:0] exc_cause, // exception cause
  output logic [63:0] exc_tval, // faulting address
  output logic done // completion pulse
);
  import sps_pkg::*;

  // ************************************************************
  // decode
  // ************************************************************
  sps_dec_if dif ();

  assign dif.rlist = rlist;
  assign dif.spimm = spimm;
  assign dif.base = base_mode;

  sps_dec u_dec (
    .dif(dif)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  // list position to register index, position 0 is ra
  function automatic logic [4:0] reg_of(input logic [3:0] i);
    logic [4:0] r;
    case (i)
      4'h0: r = `SPS_REG_RA;
      4'h1: r = `SPS_REG_S0;
      4'h2: r = `SPS_REG_S1;
      default: r = `SPS_REG_S2 + {1'b0, i} - `SPS_IDX_S2;
    endcase
    return r;
  endfunction

  sps_regs_type q;
  sps_regs_type d;
  logic [7:0] step;
  logic [63:0] mask;
  logic [63:0] ld_val;

  assign step = q.is64 ? `SPS_DWORD_BYTES : `SPS_WORD_BYTES;
  assign mask = q.is64 ? ~`SPS_RST_WORD : `SPS_MASK32;
  assign ld_val = ld_rdata & mask;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    d = q;
    d.rf_we = 1'b0;
    d.sp_we = 1'b0;
    d.pc_we = 1'b0;
    d.exc_valid = 1'b0;
    d.done = 1'b0;
    case (q.st)
      SPS_ST_IDLE:
      begin
        if (start)
        begin
          d.op = op;
          d.is64 = (base_mode == SPS_BASE_64);
          d.frame = dif.frame;
          d.sp = d.is64 ? sp_val : (sp_val & `SPS_MASK32);
          d.ld_dword = d.is64;
          if (dif.reserved)
          begin
            // trap before any load; nothing architectural moves
            d.exc_valid = 1'b1;
            d.exc_cause = `SPS_CAUSE_ILLEGAL;
            d.exc_tval = `SPS_RST_WORD;
          end
          else
          begin
            d.st = SPS_ST_ISSUE;
            d.busy = 1'b1;
            d.idx = dif.count - 4'h1;
            // q.is64 still holds the previous op here, so mask by d
            d.ld_addr = (d.sp + {56'h0, dif.frame}
              - {56'h0, (d.is64 ? `SPS_DWORD_BYTES
              : `SPS_WORD_BYTES)})
              & (d.is64 ? ~`SPS_RST_WORD : `SPS_MASK32);
          end
        end
      end
      SPS_ST_ISSUE:
      begin
        if (trap_req)
        begin
          // already written registers stay; core reruns us later
          d.st = SPS_ST_IDLE;
          d.busy = 1'b0;
        end
        else if (ld_nonidem && !NONIDEM_OK)
        begin
          d.st = SPS_ST_IDLE;
          d.busy = 1'b0;
          d.exc_valid = 1'b1;
          d.exc_cause = `SPS_CAUSE_LD_FAULT;
          d.exc_tval = q.ld_addr;
        end
        else
        begin
          d.ld_req = 1'b1;
          d.st = SPS_ST_WAIT;
        end
      end
      SPS_ST_WAIT:
      begin
        if (q.ld_req)
        begin
          if (ld_gnt)
          begin
            d.ld_req = 1'b0;
          end
        end
        else if (ld_rvalid)
        begin
          if (ld_err)
          begin
            d.st = SPS_ST_IDLE;
            d.busy = 1'b0;
            d.exc_valid = 1'b1;
            d.exc_cause = `SPS_CAUSE_LD_FAULT;
            d.exc_tval = q.ld_addr;
          end
          else
          begin
            d.rf_we = 1'b1;
            d.rf_waddr = reg_of(q.idx);
            d.rf_wdata = ld_val;
            if (q.idx == 4'h0)
            begin
              // ra is last; keep it for the return target
              d.ra = ld_val;
              d.st = SPS_ST_FINAL;
            end
            else
            begin
              d.idx = q.idx - 4'h1;
              d.ld_addr = (q.ld_addr - {56'h0, step}) & mask;
              d.st = SPS_ST_ISSUE;
            end
          end
        end
      end
      SPS_ST_FINAL:
      begin
        if (trap_req)
        begin
          d.st = SPS_ST_IDLE;
          d.busy = 1'b0;
        end
        else if (commit_ok)
        begin
          // every effect lands in one cycle so no trap splits them
          d.st = SPS_ST_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.sp_we = 1'b1;
          d.sp_wdata = (q.sp + {56'h0, q.frame}) & mask;
          if (q.op != SPS_OP_POP)
          begin
            d.pc_we = 1'b1;
            d.pc_wdata = {q.ra[63:1], 1'b0};
          end
          if (q.op == SPS_OP_POPRETZ)
          begin
            d.rf_we = 1'b1;
            d.rf_waddr = `SPS_REG_A0;
            d.rf_wdata = `SPS_RST_WORD;
          end
        end
      end
      default:
      begin
        d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign busy = q.busy;
  assign ld_req = q.ld_req;
  assign ld_addr = q.ld_addr;
  assign ld_dword = q.ld_dword;
  assign rf_we = q.rf_we;
  assign rf_waddr = q.rf_waddr;
  assign rf_wdata = q.rf_wdata;
  assign sp_we = q.sp_we;
  assign sp_wdata = q.sp_wdata;
  assign pc_we = q.pc_we;
  assign pc_wdata = q.pc_wdata;
  assign exc_valid = q.exc_valid;
  assign exc_cause = q.exc_cause;
  assign exc_tval = q.exc_tval;
  assign done = q.done;

endmodule // sps_pop_seq

// ### rtl/sps_defs.svh
// Purpose: constants of the stack-frame pop sequencer
// Assumes: included by its bare name after sps_pkg
// Notes: all sizes in bytes, all register numbers are x-indices
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH
// Overview of operation
// - list codes below 4 are reserved
// - code picks ra, s0, s1, s2 upward
// - frame is base plus extra times 16
// - 32-bit base sizes; embedded always 16
// - 64-bit base sizes from 16 to 112
// - word loads on 32-bit, else doublewords
// - load top register first, stepping down
// - load phase may be aborted and rerun
// - final step atomic, only after clean loads
// - plain pop only raises stack pointer
// - zero a0, raise sp, return via ra
// - pop-return raises sp, returns, keeps a0
// - final step waits until commit is certain
// - non-idempotent region gives load access fault

// ************************************************************
// decode
// ************************************************************
`define SPS_RLIST_MIN 4'h4
`define SPS_RLIST_MAX 4'hF
`define SPS_RLIST_E_MAX 4'h6
`define SPS_REGS_MAX 4'hD
`define SPS_K32_MAX 4'h4
`define SPS_K64_MAX 4'h7
`define SPS_K64_OFS 4'h2
`define SPS_FRAME_UNIT 8'h10

// ************************************************************
// load sizes and register numbers
// ************************************************************
`define SPS_WORD_BYTES 8'h04
`define SPS_DWORD_BYTES 8'h08
`define SPS_REG_RA 5'h01
`define SPS_REG_S0 5'h08
`define SPS_REG_S1 5'h09
`define SPS_REG_S2 5'h12
`define SPS_IDX_S2 5'h03
`define SPS_REG_A0 5'h0A

// ************************************************************
// exceptions and reset values
// ************************************************************
`define SPS_CAUSE_ILLEGAL 4'h2
`define SPS_CAUSE_LD_FAULT 4'h5
`define SPS_MASK32 64'h0000_0000_FFFF_FFFF
`define SPS_RST_WORD 64'h0000_0000_0000_0000
`endif

// ### rtl/sps_pkg.sv
// Purpose: types of the stack-frame pop sequencer
// Assumes: nothing
// Notes: datapath is always 64 bits wide
package sps_pkg;

  typedef enum logic [1:0] {
    SPS_BASE_32I = 2'h0,
    SPS_BASE_32E = 2'h1,
    SPS_BASE_64 = 2'h2
  } sps_base_type;

  typedef enum logic [1:0] {
    SPS_OP_POP = 2'h0,
    SPS_OP_POPRETZ = 2'h1,
    SPS_OP_POPRET = 2'h2
  } sps_op_type;

  typedef enum logic [2:0] {
    SPS_ST_IDLE = 3'h0,
    SPS_ST_ISSUE = 3'h1,
    SPS_ST_WAIT = 3'h3,
    SPS_ST_FINAL = 3'h2
  } sps_state_type;

  typedef struct packed {
    sps_state_type st;
    sps_op_type op;
    logic is64;
    logic [3:0] idx;
    logic [7:0] frame;
    logic [63:0] sp;
    logic [63:0] ra;
    logic busy;
    logic ld_req;
    logic [63:0] ld_addr;
    logic ld_dword;
    logic rf_we;
    logic [4:0] rf_waddr;
    logic [63:0] rf_wdata;
    logic sp_we;
    logic [63:0] sp_wdata;
    logic pc_we;
    logic [63:0] pc_wdata;
    logic exc_valid;
    logic [3:0] exc_cause;
    logic [63:0] exc_tval;
    logic done;
  } sps_regs_type;

endpackage

// ### rtl/sps_dec_if.sv
// Purpose: carries decode inputs and results between modules
// Assumes: sps_pkg compiled first
// Notes: purely combinational signals
`timescale 1ns/10ps
interface sps_dec_if;
  logic [3:0] rlist;
  logic [1:0] spimm;
  sps_pkg::sps_base_type base;
  logic reserved;
  logic [3:0] count;
  logic [7:0] frame;
  modport dec (input rlist, input spimm, input base,
    output reserved, output count, output frame);
  modport user (output rlist, output spimm, output base,
    input reserved, input count, input frame);
endinterface

// ### rtl/sps_dec.sv
// Purpose: register-list and frame-size decoder
// Assumes: list code and extra-frame field already extracted
// Notes: combinational only
`timescale 1ns/10ps
`include "sps_defs.svh"
module sps_dec (
  sps_dec_if.dec dif // decode inputs and results
);
  import sps_pkg::*;

  logic [3:0] k;

  always_comb
  begin
    k = 4'h1;
    dif.reserved = (dif.rlist < `SPS_RLIST_MIN);
    // embedded base has no s2 and up, so longer lists are unusable
    if (dif.base == SPS_BASE_32E && dif.rlist > `SPS_RLIST_E_MAX)
    begin
      dif.reserved = 1'b1;
    end
    if (dif.rlist == `SPS_RLIST_MAX)
    begin
      dif.count = `SPS_REGS_MAX;
    end
    else
    begin
      dif.count = dif.rlist - `SPS_RLIST_MIN + 4'h1;
    end
    case (dif.base)
      SPS_BASE_32E: k = 4'h1;
      SPS_BASE_32I:
      begin
        if (dif.rlist == `SPS_RLIST_MAX)
        begin
          k = `SPS_K32_MAX;
        end
        else
        begin
          k = dif.rlist >> 2;
        end
      end
      SPS_BASE_64:
      begin
        if (dif.rlist == `SPS_RLIST_MAX)
        begin
          k = `SPS_K64_MAX;
        end
        else
        begin
          k = (dif.rlist - `SPS_K64_OFS) >> 1;
        end
      end
      default: dif.reserved = 1'b1;
    endcase
    dif.frame = ({4'h0, k} + {6'h00, dif.spimm})
      * `SPS_FRAME_UNIT;
  end

endmodule // sps_dec

// ### verification/sps_pop_monitor.sv
// Purpose: port checks of the pop sequencer
// Assumes: sps_pkg compiled first
// Notes: one clock domain
`timescale 1ns/10ps
module sps_chk (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic start, // issue
  input wire sps_pkg::sps_op_type op, // flavour
  input wire logic [3:0] rlist, // list code
  input wire sps_pkg::sps_base_type base_mode, // base
  input wire logic commit_ok, // commit
  input wire logic ld_rvalid, // reply
  input wire logic ld_err, // fault
  input wire logic busy, // busy
  input wire logic ld_req, // request
  input wire logic ld_dword, // size
  input wire logic rf_we, // write
  input wire logic [4:0] rf_waddr, // index
  input wire logic sp_we, // sp write
  input wire logic pc_we, // return
  input wire logic exc_valid, // trap
  input wire logic [3:0] exc_cause, // cause
  input wire logic done // end
);
  import sps_pkg::*;
  sps_op_type op_q;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ****
  // flavour kept for the final step
  // ****
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      op_q <= SPS_OP_POP;
    else if (start && !busy)
      op_q <= op;
  sequence s_rsv;
    start && !busy && rlist < 4'h4;
  endsequence
  sequence s_ok;
    ld_rvalid && !ld_err;
  endsequence
  sequence s_fin;
    sp_we && done;
  endsequence
  reserved_trap_a: assert property (
    s_rsv |=> exc_valid && exc_cause == 4'h2 && !busy)
    else $error("reserved code missed");
  reserved_quiet_a: assert property (
    s_rsv |=> (!ld_req && !busy) [*3])
    else $error("load after reserved code");
  load_width_a: assert property (
    ld_req |-> ld_dword == (base_mode == SPS_BASE_64))
    else $error("wrong load size");
  restore_write_a: assert property (
    s_ok |=> rf_we && rf_waddr != 5'h00)
    else $error("load not written");
  fault_stop_a: assert property (
    ld_rvalid && ld_err |=> exc_valid && exc_cause == 4'h5 &&
    !busy && !sp_we)
    else $error("fault not stopping");
  final_once_a: assert property (
    sp_we |-> done && !busy && !exc_valid)
    else $error("final step split");
  done_final_a: assert property (
    done |-> sp_we)
    else $error("done without sp");
  commit_gate_a: assert property (
    sp_we |-> $past(commit_ok))
    else $error("final before commit");
  ret_with_sp_a: assert property (
    pc_we |-> s_fin)
    else $error("return without sp");
  pop_only_a: assert property (
    sp_we && op_q == SPS_OP_POP |-> !pc_we && !rf_we)
    else $error("pop did more");
  zero_ret_a: assert property (
    sp_we && op_q == SPS_OP_POPRETZ |-> pc_we && rf_we &&
    rf_waddr == 5'h0A)
    else $error("zero return wrong");
  ret_keep_a: assert property (
    sp_we && op_q == SPS_OP_POPRET |-> pc_we && !rf_we)
    else $error("return touched a0");
endmodule // sps_chk
bind sps_pop_seq sps_chk chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .start(start),
  .op(op),
  .rlist(rlist),
  .base_mode(base_mode),
  .commit_ok(commit_ok),
  .ld_rvalid(ld_rvalid),
  .ld_err(ld_err),
  .busy(busy),
  .ld_req(ld_req),
  .ld_dword(ld_dword),
  .rf_we(rf_we),
  .rf_waddr(rf_waddr),
  .sp_we(sp_we),
  .pc_we(pc_we),
  .exc_valid(exc_valid),
  .exc_cause(exc_cause),
  .done(done)
);

// ### verification/sps_mem_model.sv
// Purpose: data memory on the load port
// Assumes: one load in flight
// Notes: word at a is {~a, a^5A5A5A5A}
`timescale 1ns/10ps
module sps_mem (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic slow, // stall
  input wire logic [63:0] err_addr, // faulting word
  input wire logic [63:0] ni_addr, // non-idempotent word
  input wire logic ld_req, // request
  input wire logic [63:0] ld_addr, // address
  output logic ld_gnt, // grant
  output logic ld_nonidem, // attribute
  output logic ld_rvalid, // reply
  output logic [63:0] ld_rdata, // data
  output logic ld_err // fault
);
  logic pend;
  logic [1:0] cnt;
  logic [63:0] a;
  assign ld_nonidem = ld_addr == ni_addr;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      ld_gnt <= 1'b0;
      ld_rvalid <= 1'b0;
      ld_err <= 1'b0;
      ld_rdata <= '1;
      pend <= 1'b0;
      cnt <= 2'h0;
      a <= '0;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      ld_rvalid <= 1'b0;
      ld_err <= 1'b0;
      // released bus alternates between the last word and its inverse
      ld_rdata <= ~ld_rdata;
      ld_gnt <= ld_req && !ld_gnt && !pend && (!slow || cnt == 2'h3);
      if (ld_gnt)
      begin
        pend <= 1'b1;
        a <= ld_addr;
      end
      if (pend && (!slow || cnt[0]))
      begin
        pend <= 1'b0;
        ld_rvalid <= 1'b1;
        ld_err <= a == err_addr;
        ld_rdata <= {~a[31:0], a[31:0] ^ 32'h5A5A_5A5A};
      end
    end
endmodule // sps_mem

// ### verification/tb.sv
// Purpose: self-checking bench of the pop sequencer
// Assumes: sps_mem answers the load port
// Notes: expected results pass through one queue
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %h got %h", n, e, s); \
  end end
module tb;
  import sps_pkg::*;
  typedef struct packed {
    logic [2:0] k;
    logic [4:0] i;
    logic [63:0] v;
  } sps_note_type;
  sps_note_type exp_q[$];
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'hfe5c1276;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  sps_base_type base_mode = SPS_BASE_32I;
  sps_op_type op = SPS_OP_POP;
  logic start = 1'b0;
  logic [3:0] rlist = 4'h4;
  logic [1:0] spimm = 2'h0;
  logic [63:0] sp_val = 64'h0;
  logic trap_req = 1'b0;
  logic commit_ok = 1'b1;
  logic slow = 1'b0;
  logic [63:0] err_addr = 64'h1;
  logic [63:0] ni_addr = 64'h1;
  logic ld_gnt, ld_nonidem, ld_rvalid, ld_err, busy, ld_req, ld_dword;
  logic rf_we, sp_we, pc_we, exc_valid, done;
  logic [63:0] ld_rdata, ld_addr, rf_wdata, sp_wdata, pc_wdata, exc_tval;
  logic [4:0] rf_waddr;
  logic [3:0] exc_cause;
  sps_pop_seq #(.NONIDEM_OK(1'b0)) uut (
    .ref_clk(ref_clk),
    .rst(rst),
    .base_mode(base_mode),
    .start(start),
    .op(op),
    .rlist(rlist),
    .spimm(spimm),
    .sp_val(sp_val),
    .trap_req(trap_req),
    .commit_ok(commit_ok),
    .ld_gnt(ld_gnt),
    .ld_nonidem(ld_nonidem),
    .ld_rvalid(ld_rvalid),
    .ld_rdata(ld_rdata),
    .ld_err(ld_err),
    .busy(busy),
    .ld_req(ld_req),
    .ld_addr(ld_addr),
    .ld_dword(ld_dword),
    .rf_we(rf_we),
    .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata),
    .sp_we(sp_we),
    .sp_wdata(sp_wdata),
    .pc_we(pc_we),
    .pc_wdata(pc_wdata),
    .exc_valid(exc_valid),
    .exc_cause(exc_cause),
    .exc_tval(exc_tval),
    .done(done)
  );
  sps_mem mem (
    .ref_clk(ref_clk),
    .rst(rst),
    .slow(slow),
    .err_addr(err_addr),
    .ni_addr(ni_addr),
    .ld_req(ld_req),
    .ld_addr(ld_addr),
    .ld_gnt(ld_gnt),
    .ld_nonidem(ld_nonidem),
    .ld_rvalid(ld_rvalid),
    .ld_rdata(ld_rdata),
    .ld_err(ld_err)
  );
  initial
    forever #5 ref_clk = ~ref_clk;
  task automatic note(input logic [2:0] k, input logic [4:0] i,
      input logic [63:0] v);
    exp_q.push_back({k, i, v});
  endtask
  task automatic take(input logic [2:0] k, input logic [4:0] i,
      input logic [63:0] v);
    sps_note_type g;
    g = '0;
    `CHK("note", 1'b1, exp_q.size() != 0)
    if (exp_q.size() != 0)
      g = exp_q.pop_front();
    `CHK("kind", k, g.k)
    `CHK("index", i, g.i)
    `CHK("value", v, g.v)
  endtask
  // ****
  // result watcher
  // ****
  always @(negedge ref_clk)
    if (!rst)
    begin
      if (ld_req && ld_gnt)
        take(3'h4, {4'h0, ld_dword}, ld_addr);
      if (rf_we)
        take(3'h0, rf_waddr, rf_wdata);
      if (sp_we)
        take(3'h1, 5'h00, sp_wdata);
      if (pc_we)
        take(3'h2, 5'h00, pc_wdata);
      if (exc_valid)
        take(3'h3, {1'b0, exc_cause}, exc_tval);
    end
  // ****
  // driver: md 1 trap, 2 fault on 2nd load, 3 non-idempotent
  // ****
  task automatic run_op(input int b, input int r, input int md);
    sps_base_type bm;
    logic [63:0] w, fr, m, ad, d, ra;
    logic f;
    int n;
    int x;
    bm = sps_base_type'(b);
    w = bm == SPS_BASE_64 ? 64'h8 : 64'h4;
    m = bm == SPS_BASE_64 ? '1 : 64'hFFFF_FFFF;
    @(negedge ref_clk);
    base_mode = bm;
    op = sps_op_type'((r + b) % 4);
    rlist = 4'(r);
    spimm = 2'($random(seed));
    slow = 1'($random(seed));
    sp_val = {$random(seed), $random(seed)} & m & ~64'hF;
    if (bm == SPS_BASE_32E)
      fr = 64'h10;
    else if (bm == SPS_BASE_64)
      fr = r < 14 ? 64'(r / 2 - 1) * 64'h10 : 64'(r - 8) * 64'h10;
    else
      fr = r < 8 ? 64'h10 : r < 12 ? 64'h20 : r < 15 ? 64'h30 : 64'h40;
    fr = fr + 64'(spimm) * 64'h10;
    n = r == 15 ? 13 : r - 3;
    ad = (sp_val + fr - w) & m;
    if (md == 2)
      err_addr = (ad - w) & m;
    if (md == 3)
      ni_addr = ad;
    // embedded base cannot hold the upper saved registers
    if (b > 2 || r < 4 || (bm == SPS_BASE_32E && r > 6))
      note(3'h3, 5'h02, 64'h0);
    else
    begin
      f = 1'b0;
      for (x = n - 1; x >= 0 && !f; x--)
      begin
        d = {~ad[31:0], ad[31:0] ^ 32'h5A5A_5A5A};
        d = bm == SPS_BASE_64 ? d : {32'h0, d[31:0]};
        ra = d;
        if (ad != ni_addr)
          note(3'h4, {4'h0, w[3]}, ad);
        if (ad == ni_addr || ad == err_addr)
          note(3'h3, 5'h05, ad);
        else
          note(3'h0, x == 0 ? 5'h01 : 5'(x < 3 ? x + 7 : x + 15), d);
        f = md == 1 || ad == ni_addr || ad == err_addr;
        ad = (ad - w) & m;
      end
      if (!f)
      begin
        if (op == SPS_OP_POPRETZ)
          note(3'h0, 5'h0A, 64'h0);
        note(3'h1, 5'h00, (sp_val + fr) & m);
        if (op != SPS_OP_POP)
          note(3'h2, 5'h00, ra & ~64'h1);
      end
    end
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    x = 0;
    while (busy && x < 500)
    begin
      if (md == 1 && rf_we)
        trap_req = 1'b1;
      commit_ok = 1'($random(seed));
      @(negedge ref_clk);
      x++;
    end
    `CHK("busy", 1'b0, busy)
    trap_req = 1'b0;
    commit_ok = 1'b1;
    err_addr = 64'h1;
    ni_addr = 64'h1;
    @(negedge ref_clk);
    #1;
    `CHK("pending", 0, exp_q.size())
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    results();
  end
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    for (int b = 0; b < 3; b++)
      for (int r = 0; r < 16; r++)
        run_op(b, r, 0);
    $display("test sweep done");
    run_op(2, 15, 1);
    run_op(2, 15, 0);
    run_op(0, 4, 1);
    run_op(0, 4, 0);
    $display("test restart done");
    run_op(0, 15, 2);
    run_op(2, 9, 3);
    run_op(3, 8, 0);
    $display("test fault done");
    results();
  end
endmodule // tb
